/* File: logic/uil_par_if.sv */
// carrier between the control block and its parity unit
// assumes both ends sit on the same core clock
interface uil_par_if;
    logic [7:0] tx_data;     // byte being transmitted
    logic [7:0] rx_data;     // byte just received
    logic       rx_par_bit;  // parity bit received with it
    logic       parity_en;   // parity_enable
    logic       stick;       // stick_parity
    logic       even;        // even_parity_select
    logic       tx_par_bit;  // registered parity to send
    logic       rx_par_err;  // registered check result

    modport ctl  (output tx_data, rx_data, rx_par_bit, parity_en, stick, even,
                  input  tx_par_bit, rx_par_err);
    modport unit (input  tx_data, rx_data, rx_par_bit, parity_en, stick, even,
                  output tx_par_bit, rx_par_err);
endinterface

/* File: logic/uil_parity.sv */
// parity generator and checker for the line-control block
// assumes byte inputs are already masked to the chosen word length
module uil_parity (
    input  wire logic i_core_clk, // core clock
    input  wire logic i_srst,     // synchronous reset, active high
    uil_par_if.unit   par         // link to the control block
);

    uil_pkg::uil_par_s s_reg;
    uil_pkg::uil_par_s s_next;

    // =====================================================================
    // expected parity bit for one byte under the current settings
    function automatic logic want_par(input logic [7:0] d, input logic stick,
                                      input logic even);
        logic r;
        r = 1'b0;
        if (stick) begin
            r = ~even;
        end else if (even) begin
            r = ^d;
        end else begin
            r = ~^d;
        end
        return r;
    endfunction

    // the same function serves both directions so they can never disagree
    always_comb begin
        s_next        = s_reg;
        s_next.tx_par = want_par(par.tx_data, par.stick, par.even);
        s_next.rx_err = par.parity_en &
                        (par.rx_par_bit != want_par(par.rx_data, par.stick, par.even));
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign par.tx_par_bit = s_reg.tx_par;
    assign par.rx_par_err = s_reg.rx_err;

    // constant parity under stick mode
    stick_par_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        par.stick |=> par.tx_par_bit == !$past(par.even))
        else $error("stick parity bit wrong");

    // a disabled parity never reports an error
    no_par_err_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !par.parity_en |=> !par.rx_par_err)
        else $error("parity error with parity off");

endmodule

/* File: logic/uil_pkg.sv */
// constants and state types for the uart interrupt and line-control block
// assumes a 16-bit register port in which every register offset is a byte address
package uil_pkg;

    // =====================================================================
    // register byte addresses
    localparam logic [31:0] ADDR_DATA  = 32'h4000_5000; // tx holding on write, rx buffer on read
    localparam logic [31:0] ADDR_IEN   = 32'h4000_5004; // uart_irq_dma_enable
    localparam logic [31:0] ADDR_IIR   = 32'h4000_5008; // uart_irq_identify
    localparam logic [31:0] ADDR_LCR   = 32'h4000_500C; // uart_line_control
    localparam logic [31:0] ADDR_LSR   = 32'h4000_5014; // line_status_register
    localparam logic [31:0] ADDR_MSR   = 32'h4000_5018; // modem_status_register

    // =====================================================================
    // field positions and masks
    localparam int          IEN_RX_FULL   = 0;   // receive_full_irq_enable
    localparam int          IEN_TX_EMPTY  = 1;   // transmit_empty_irq_enable
    localparam int          IEN_RX_STAT   = 2;   // receive_status_irq_enable
    localparam int          IEN_MODEM     = 3;   // modem_status_irq_enable
    localparam int          IEN_TX_DMA    = 4;   // transmit_dma_enable
    localparam int          IEN_RX_DMA    = 5;   // receive_dma_enable
    localparam logic [15:0] IEN_MASK      = 16'h003F;
    localparam int          LCR_BREAK     = 6;   // force_break
    localparam int          LCR_STICK     = 5;   // stick_parity
    localparam int          LCR_EVEN      = 4;   // even_parity_select
    localparam int          LCR_PARITY    = 3;   // parity_enable
    localparam int          LCR_STOP      = 2;
    localparam int          LCR_WLS_LO    = 0;
    localparam logic [15:0] LCR_MASK      = 16'h007F;
    localparam logic [15:0] IIR_RESET     = 16'h0001;
    localparam logic [1:0]  FIFO_MODE_ON  = 2'h3;
    localparam logic [1:0]  FIFO_MODE_OFF = 2'h0;

    // =====================================================================
    // irq_source_code values
    localparam logic [2:0]  CODE_MODEM    = 3'h0;
    localparam logic [2:0]  CODE_TX_EMPTY = 3'h1;
    localparam logic [2:0]  CODE_RX_FULL  = 3'h2;
    localparam logic [2:0]  CODE_LINE     = 3'h3;
    localparam logic [2:0]  CODE_TIMEOUT  = 3'h6;

    // =====================================================================
    // state of the top module
    typedef struct packed {
        logic [15:0] ien;        // uart_irq_dma_enable storage
        logic [15:0] lcr;        // uart_line_control storage
        logic        msr_flag;   // modem status change pending
        logic        ls_flag;    // receive line status pending
        logic        rx_flag;    // receive buffer full pending
        logic        to_flag;    // receive timeout pending
        logic        thre_flag;  // transmit holding empty pending
        logic        tx_empty_d; // previous transmit empty level
        logic [15:0] rdata;      // read data register
        logic        sout;       // serial_output_pin
        logic        irq;        // combined interrupt line
        logic        tx_dma;     // transmit dma request
        logic        rx_dma;     // receive dma request
    } uil_state_s;

    localparam uil_state_s ST_RESET = '0;

    // state of the parity unit
    typedef struct packed {
        logic tx_par;            // parity bit to transmit
        logic rx_err;            // received parity mismatch
    } uil_par_s;

endpackage

/* File: logic/uil_top.sv */
// interrupt identification, irq/dma enables and line-control bits of a uart
// assumes the shifters, fifos and status registers live elsewhere and feed
// this block with one-cycle event pulses and levels on the core clock
//
// Decided for this implementation: the plain strobed port.

// Notes on behaviour
// - enable bits 3:0 irqs, 5:4 dma
// - rx dma request only when bit5 set
// - tx dma request only when bit4 set
// - bit3 enables modem change interrupts
// - bit2 enables line status interrupts
// - bit1 enables transmit empty interrupts
// - bit0 enables receive full interrupts
// - identify bits 7:6 show fifo mode
// - code 000 modem, cleared by status read
// - code 001 tx empty, write or identify-read clears
// - code 010 rx full, buffer read clears
// - code 110 rx timeout, buffer read clears
// - code 011 line status, status read clears
// - bit0 active-low pending, resets to one
// - break bit forces serial output low
// - stick parity sends constant inverse of even-select
// - normal parity odd or even by select
// - enabling tx irq while empty fires at once
module uil_top (
    input  wire logic        i_core_clk,       // core clock, 50 MHz
    input  wire logic        i_srst,           // synchronous reset, active high
    input  wire logic [31:0] i_addr,           // register byte address
    input  wire logic [15:0] i_wdata,          // write data
    input  wire logic        i_wr,             // write strobe
    input  wire logic        i_rd,             // read strobe
    output logic      [15:0] o_rdata,          // read data, cycle after read
    input  wire logic        i_fifo_en,        // fifos enabled level
    input  wire logic        i_rx_data_evt,    // a received byte was loaded
    input  wire logic        i_rx_timeout_evt, // receive fifo timed out
    input  wire logic        i_line_err_evt,   // receive line status event
    input  wire logic [3:0]  i_msr_change,     // modem status change bits set
    input  wire logic        i_tx_empty,       // transmit holding empty level
    input  wire logic        i_tx_serial,      // serial bit from transmitter
    input  wire logic        i_tx_dma_want,    // transmitter wants data
    input  wire logic        i_rx_dma_want,    // receiver has data
    input  wire logic [7:0]  i_tx_byte,        // byte to send
    input  wire logic [7:0]  i_rx_byte,        // byte received
    input  wire logic        i_rx_par_bit,     // parity bit received
    output logic             o_sout,           // serial_output_pin
    output logic             o_irq,            // interrupt, active high
    output logic             o_tx_dma_req,     // transmit dma request
    output logic             o_rx_dma_req,     // receive dma request
    output logic             o_tx_par_bit,     // parity bit to send
    output logic             o_rx_par_err,     // received parity mismatch
    output logic             o_parity_on,      // parity_enable
    output logic             o_two_stop,       // extra stop bits selected
    output logic      [1:0]  o_word_len        // word length select
);

    uil_pkg::uil_state_s s_reg;
    uil_pkg::uil_state_s s_next;
    uil_par_if           par ();

    logic       pend;       // some enabled source pending
    logic [2:0] code;       // irq_source_code of highest source
    logic [3:0] msr_hit;    // per-bit modem change enabled
    logic       wr_ien;
    logic       wr_lcr;
    logic       wr_thr;
    logic       rd_iir;
    logic       rd_rbr;
    logic       rd_lsr;
    logic       rd_msr;

    // =====================================================================
    // address decode, used for every strobe
    function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
        return a == off;
    endfunction

    assign wr_ien = i_wr & hit(i_addr, uil_pkg::ADDR_IEN);
    assign wr_lcr = i_wr & hit(i_addr, uil_pkg::ADDR_LCR);
    assign wr_thr = i_wr & hit(i_addr, uil_pkg::ADDR_DATA);
    assign rd_iir = i_rd & hit(i_addr, uil_pkg::ADDR_IIR);
    assign rd_rbr = i_rd & hit(i_addr, uil_pkg::ADDR_DATA);
    assign rd_lsr = i_rd & hit(i_addr, uil_pkg::ADDR_LSR);
    assign rd_msr = i_rd & hit(i_addr, uil_pkg::ADDR_MSR);

    // =====================================================================
    // modem change bits, each gated by the modem enable
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_msr
            assign msr_hit[gi] = i_msr_change[gi] & s_reg.ien[uil_pkg::IEN_MODEM];
        end
    endgenerate

    // =====================================================================
    // priority encoder over the pending flags
    always_comb begin
        pend = 1'b1;
        code = uil_pkg::CODE_MODEM;
        if (s_reg.ls_flag && s_reg.ien[uil_pkg::IEN_RX_STAT]) begin
            code = uil_pkg::CODE_LINE;
        end else if (s_reg.rx_flag && s_reg.ien[uil_pkg::IEN_RX_FULL]) begin
            code = uil_pkg::CODE_RX_FULL;
        end else if (s_reg.to_flag && s_reg.ien[uil_pkg::IEN_RX_FULL]) begin
            code = uil_pkg::CODE_TIMEOUT;
        end else if (s_reg.thre_flag && s_reg.ien[uil_pkg::IEN_TX_EMPTY]) begin
            code = uil_pkg::CODE_TX_EMPTY;
        end else if (s_reg.msr_flag && s_reg.ien[uil_pkg::IEN_MODEM]) begin
            code = uil_pkg::CODE_MODEM;
        end else begin
            pend = 1'b0;
        end
    end

    // =====================================================================
    // next state: registers, sticky flags (set beats clear), outputs
    always_comb begin
        s_next            = s_reg;
        s_next.tx_empty_d = i_tx_empty;

        if (wr_ien) begin
            s_next.ien = i_wdata & uil_pkg::IEN_MASK;
        end
        if (wr_lcr) begin
            s_next.lcr = i_wdata & uil_pkg::LCR_MASK;
        end

        if (rd_msr) begin
            s_next.msr_flag = 1'b0;
        end
        if (|msr_hit) begin
            s_next.msr_flag = 1'b1;
        end

        if (rd_lsr) begin
            s_next.ls_flag = 1'b0;
        end
        if (i_line_err_evt) begin
            s_next.ls_flag = 1'b1;
        end

        if (rd_rbr) begin
            s_next.rx_flag = 1'b0;
            s_next.to_flag = 1'b0;
        end
        if (i_rx_data_evt) begin
            s_next.rx_flag = 1'b1;
        end
        if (i_rx_timeout_evt) begin
            s_next.to_flag = 1'b1;
        end

        if (wr_thr || (rd_iir && pend && code == uil_pkg::CODE_TX_EMPTY)) begin
            s_next.thre_flag = 1'b0;
        end
        if (i_tx_empty && !s_reg.tx_empty_d) begin
            s_next.thre_flag = 1'b1;
        end
        if (wr_ien && i_wdata[uil_pkg::IEN_TX_EMPTY] &&
            !s_reg.ien[uil_pkg::IEN_TX_EMPTY] && i_tx_empty) begin
            s_next.thre_flag = 1'b1;
        end

        // read data; addresses owned by other blocks answer zero here
        s_next.rdata = 16'h0000;
        if (i_rd) begin
            case (1'b1)
                hit(i_addr, uil_pkg::ADDR_IEN): begin
                    s_next.rdata = s_reg.ien;
                end
                hit(i_addr, uil_pkg::ADDR_LCR): begin
                    s_next.rdata = s_reg.lcr;
                end
                hit(i_addr, uil_pkg::ADDR_IIR): begin
                    s_next.rdata = {8'h00,
                                    i_fifo_en ? uil_pkg::FIFO_MODE_ON : uil_pkg::FIFO_MODE_OFF,
                                    2'h0, code, ~pend};
                end
                default: begin
                    s_next.rdata = 16'h0000;
                end
            endcase
        end

        s_next.sout   = s_reg.lcr[uil_pkg::LCR_BREAK] ? 1'b0 : i_tx_serial;
        s_next.irq    = pend;
        s_next.tx_dma = s_reg.ien[uil_pkg::IEN_TX_DMA] & i_tx_dma_want;
        s_next.rx_dma = s_reg.ien[uil_pkg::IEN_RX_DMA] & i_rx_dma_want;
    end

    // =====================================================================
    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s_reg <= uil_pkg::ST_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // =====================================================================
    // parity unit, fed straight from the line-control storage
    assign par.tx_data    = i_tx_byte;
    assign par.rx_data    = i_rx_byte;
    assign par.rx_par_bit = i_rx_par_bit;
    assign par.parity_en  = s_reg.lcr[uil_pkg::LCR_PARITY];
    assign par.stick      = s_reg.lcr[uil_pkg::LCR_STICK];
    assign par.even       = s_reg.lcr[uil_pkg::LCR_EVEN];

    uil_parity u_parity (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .par        (par.unit)
    );

    // outputs, all from flops
    assign o_rdata      = s_reg.rdata;
    assign o_sout       = s_reg.sout;
    assign o_irq        = s_reg.irq;
    assign o_tx_dma_req = s_reg.tx_dma;
    assign o_rx_dma_req = s_reg.rx_dma;
    assign o_tx_par_bit = par.tx_par_bit;
    assign o_rx_par_err = par.rx_par_err;
    assign o_parity_on  = s_reg.lcr[uil_pkg::LCR_PARITY];
    assign o_two_stop   = s_reg.lcr[uil_pkg::LCR_STOP];
    assign o_word_len   = s_reg.lcr[uil_pkg::LCR_WLS_LO +: 2];

    // =====================================================================
    // checks
    tx_dma_gate_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        o_tx_dma_req |-> $past(s_reg.ien[uil_pkg::IEN_TX_DMA] && i_tx_dma_want))
        else $error("tx dma request while disabled");

    rx_dma_gate_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        o_rx_dma_req |-> $past(s_reg.ien[uil_pkg::IEN_RX_DMA] && i_rx_dma_want))
        else $error("rx dma request while disabled");

    break_low_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        s_reg.lcr[uil_pkg::LCR_BREAK] |=> !o_sout)
        else $error("serial output not low during break");

    pend_flag_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        rd_iir |=> o_rdata[0] == !$past(pend) && o_rdata[15:8] == 8'h00)
        else $error("identify pending flag wrong");

    thre_clear_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (wr_thr && !(i_tx_empty && !s_reg.tx_empty_d) && !wr_ien) |=> !s_reg.thre_flag)
        else $error("tx empty not cleared by holding write");

    msr_clear_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (rd_msr && !(|msr_hit)) |=> !s_reg.msr_flag)
        else $error("modem flag not cleared by status read");

    line_first_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (rd_iir && s_reg.ls_flag && s_reg.ien[uil_pkg::IEN_RX_STAT])
        |=> o_rdata[3:1] == uil_pkg::CODE_LINE && !o_rdata[0])
        else $error("line status not reported first");

    thre_now_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (wr_ien && i_wdata[uil_pkg::IEN_TX_EMPTY] && !s_reg.ien[uil_pkg::IEN_TX_EMPTY]
         && i_tx_empty) |=> s_reg.thre_flag ##1 o_irq)
        else $error("tx empty irq not raised at once");

    ien_rsvd_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_rd && hit(i_addr, uil_pkg::ADDR_IEN)) |=> o_rdata[15:6] == 10'h000)
        else $error("reserved enable bits not zero");

    modem_irq_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        ((|i_msr_change) && s_reg.ien[uil_pkg::IEN_MODEM] && !wr_ien)
        ##1 (!rd_msr && !wr_ien) |=> o_irq)
        else $error("modem change did not raise irq");

    // dma enables alone must never reach the interrupt line
    irq_gate_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (s_reg.ien[uil_pkg::IEN_MODEM:uil_pkg::IEN_RX_FULL] == 4'h0) |=> !o_irq)
        else $error("irq raised with all irq enables off");

    fifo_bits_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        rd_iir |=> o_rdata[7:4] == ($past(i_fifo_en) ? 4'hC : 4'h0))
        else $error("identify fifo field wrong");

    rx_clear_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (rd_rbr && !i_rx_data_evt) |=> !s_reg.rx_flag)
        else $error("receive flag not cleared by buffer read");

    ls_clear_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (rd_lsr && !i_line_err_evt) |=> !s_reg.ls_flag)
        else $error("line flag not cleared by status read");

endmodule

/* File: test/testbench.sv */
// self-checking bench for uil_top
// assumes the register port and one-cycle event timing of uil_top
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, i_fifo_en = 0;
    logic        i_rx_data_evt = 0, i_rx_timeout_evt = 0, i_line_err_evt = 0;
    logic        i_tx_empty = 0, i_tx_serial = 1, i_tx_dma_want = 0, i_rx_dma_want = 0;
    logic        par_en = 0, stick = 0, even = 0, corrupt = 0, i_rx_par_bit;
    logic [3:0]  i_msr_change = 4'h0;
    logic [7:0]  i_tx_byte = 8'h07, i_rx_byte;
    logic [15:0] i_wdata = 16'h0000, o_rdata, rv;
    logic [31:0] i_addr = 32'h0000_0000;
    logic        o_sout, o_irq, o_tx_dma_req, o_rx_dma_req, o_tx_par_bit, o_rx_par_err;
    logic        o_parity_on, o_two_stop;
    logic [1:0]  o_word_len;
    int          mismatches = 0, check_count = 0, cycles = 0;
    // =====================================================================
    // clock, watchdog and instances
    // clock at 50 MHz
    always #10 i_core_clk = ~i_core_clk;
    // cut a hang short well past the expected run length
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    uil_top uil_top_i (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_fifo_en(i_fifo_en), .i_rx_data_evt(i_rx_data_evt),
        .i_rx_timeout_evt(i_rx_timeout_evt), .i_line_err_evt(i_line_err_evt),
        .i_msr_change(i_msr_change), .i_tx_empty(i_tx_empty), .i_tx_serial(i_tx_serial),
        .i_tx_dma_want(i_tx_dma_want), .i_rx_dma_want(i_rx_dma_want),
        .i_tx_byte(i_tx_byte), .i_rx_byte(i_rx_byte), .i_rx_par_bit(i_rx_par_bit),
        .o_sout(o_sout), .o_irq(o_irq), .o_tx_dma_req(o_tx_dma_req),
        .o_rx_dma_req(o_rx_dma_req), .o_tx_par_bit(o_tx_par_bit),
        .o_rx_par_err(o_rx_par_err), .o_parity_on(o_parity_on), .o_two_stop(o_two_stop),
        .o_word_len(o_word_len));
    uil_remote uil_remote_i (.i_byte(i_tx_byte), .i_par_en(par_en), .i_stick(stick),
        .i_even(even), .i_corrupt(corrupt), .o_rx_byte(i_rx_byte),
        .o_rx_par_bit(i_rx_par_bit));
    // =====================================================================
    // shared tasks
    task automatic stop_test();
        $display("mismatches=%0d check_count=%0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // settle 1 ns past the last edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] a);
        @(posedge i_core_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [15:0] exp);
        rd(a);
        check(rv, exp);
    endtask
    task automatic pulse_evt(input logic ln, input logic rx, input logic to, input logic [3:0] m);
        @(posedge i_core_clk);
        i_line_err_evt <= ln; i_rx_data_evt <= rx; i_rx_timeout_evt <= to; i_msr_change <= m;
        @(posedge i_core_clk);
        i_line_err_evt <= 0; i_rx_data_evt <= 0; i_rx_timeout_evt <= 0; i_msr_change <= 0;
        tick(2);
    endtask
    // =====================================================================
    // scenarios
    task automatic t_regs();
        rdc(uil_pkg::ADDR_IEN, 16'h0000);
        rdc(uil_pkg::ADDR_IIR, 16'h0001);
        rdc(uil_pkg::ADDR_LCR, 16'h0000);
        wr(uil_pkg::ADDR_IEN, 16'hFFFF);
        rdc(uil_pkg::ADDR_IEN, 16'h003F);
        wr(uil_pkg::ADDR_LCR, 16'hFFFF);
        rdc(uil_pkg::ADDR_LCR, 16'h007F);
        check({o_two_stop, o_word_len}, 16'h0007);
        wr(uil_pkg::ADDR_IEN, 16'h0000);
        wr(uil_pkg::ADDR_LCR, 16'h0000);
        rdc(uil_pkg::ADDR_IIR, 16'h0001);
    endtask
    task automatic t_dma();
        @(posedge i_core_clk);
        i_tx_dma_want <= 1; i_rx_dma_want <= 1;
        tick(2);
        check({o_tx_dma_req, o_rx_dma_req}, 16'h0000);
        wr(uil_pkg::ADDR_IEN, 16'h0010);
        tick(2);
        check({o_tx_dma_req, o_rx_dma_req}, 16'h0002);
        wr(uil_pkg::ADDR_IEN, 16'h0020);
        tick(2);
        check({o_tx_dma_req, o_rx_dma_req}, 16'h0001);
        wr(uil_pkg::ADDR_IEN, 16'h0000);
    endtask
    task automatic t_prio();
        pulse_evt(1, 0, 0, 4'h0);
        check(o_irq, 0);
        rd(uil_pkg::ADDR_LSR);
        wr(uil_pkg::ADDR_IEN, 16'h0005);
        pulse_evt(1, 1, 0, 4'h0);
        check(o_irq, 1);
        rdc(uil_pkg::ADDR_IIR, 16'h0006);
        rd(uil_pkg::ADDR_LSR);
        rdc(uil_pkg::ADDR_IIR, 16'h0004);
        rd(uil_pkg::ADDR_DATA);
        rdc(uil_pkg::ADDR_IIR, 16'h0001);
        pulse_evt(0, 0, 1, 4'h0);
        rdc(uil_pkg::ADDR_IIR, 16'h000C);
        rd(uil_pkg::ADDR_DATA);
        tick(2);
        check(o_irq, 0);
        wr(uil_pkg::ADDR_IEN, 16'h0000);
    endtask
    task automatic t_tx();
        wr(uil_pkg::ADDR_IEN, 16'h0002);
        i_tx_empty <= 1;
        tick(3);
        check(o_irq, 1);
        wr(uil_pkg::ADDR_DATA, 16'h0055);
        tick(2);
        check(o_irq, 0);
        wr(uil_pkg::ADDR_IEN, 16'h0000);
        wr(uil_pkg::ADDR_IEN, 16'h0002);
        tick(3);
        check(o_irq, 1);
        rdc(uil_pkg::ADDR_IIR, 16'h0002);
        rdc(uil_pkg::ADDR_IIR, 16'h0001);
        check(o_irq, 0);
        @(posedge i_core_clk);
        i_tx_empty <= 0;
        wr(uil_pkg::ADDR_IEN, 16'h0000);
    endtask
    task automatic t_modem();
        pulse_evt(0, 0, 0, 4'h1);
        check(o_irq, 0);
        wr(uil_pkg::ADDR_IEN, 16'h0008);
        i_fifo_en <= 1;
        pulse_evt(0, 0, 0, 4'h8);
        check(o_irq, 1);
        rdc(uil_pkg::ADDR_IIR, 16'h00C0);
        rd(uil_pkg::ADDR_MSR);
        rdc(uil_pkg::ADDR_IIR, 16'h00C1);
        @(posedge i_core_clk);
        i_fifo_en <= 0;
        wr(uil_pkg::ADDR_IEN, 16'h0000);
    endtask
    task automatic t_line();
        logic [3:0] exp_par;
        exp_par = 4'b0110; // byte 0x07 has odd weight
        tick(2);
        check(o_sout, 1);
        wr(uil_pkg::ADDR_LCR, 16'h0040);
        tick(2);
        check(o_sout, 0);
        for (int k = 0; k < 4; k++) begin
            wr(uil_pkg::ADDR_LCR, 16'h0008 | (k[1:0] << 4));
            par_en <= 1; stick <= k[1]; even <= k[0]; corrupt <= 0;
            tick(2);
            check(o_tx_par_bit, exp_par[k]);
            check({o_parity_on, o_rx_par_err}, 16'h0002);
            @(posedge i_core_clk);
            corrupt <= 1;
            tick(2);
            check(o_rx_par_err, 1);
        end
        wr(uil_pkg::ADDR_LCR, 16'h0020);
        par_en <= 0;
        tick(2);
        check({o_parity_on, o_rx_par_err}, 16'h0000);
    endtask
    // =====================================================================
    // main sequence
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_srst <= 0;
        t_regs();
        t_dma();
        t_prio();
        t_tx();
        t_modem();
        t_line();
        stop_test();
    end
endmodule

/* File: test/uil_remote.sv */
// far-end serial device model: sends a byte with its parity bit
// assumes the bench sets framing to match the line-control register
module uil_remote (
    input  wire logic [7:0] i_byte,       // byte sent by the remote
    input  wire logic       i_par_en,     // parity framing on
    input  wire logic       i_stick,      // stick parity framing
    input  wire logic       i_even,       // even parity framing
    input  wire logic       i_corrupt,    // flip the parity bit
    output logic      [7:0] o_rx_byte,    // byte on the wire
    output logic            o_rx_par_bit  // parity bit on the wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // framing
    // remote parity framing
    assign o_rx_byte    = i_byte;
    // no parity slot without framing: show the inverse so stale values never match
    assign o_rx_par_bit = i_corrupt ^ (!i_par_en ? ~^i_byte :
                          i_stick ? ~i_even : (i_even ? ^i_byte : ~^i_byte));
endmodule
